// ===== shared/pcr_pkg.sv
// Shared constants and types for the clock and reset control block
package pcr_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int LOCK_TIME_US = 100;
	localparam int LOCK_CYCLES = (LOCK_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WAKE_CLOCKS = 4096;
	localparam int SWITCH_GAP = 2;
	localparam int MULT_W = 5;
	localparam int DIV_W = 2;
	localparam int KHZ_W = 20;
	localparam int FREQ_W = 32;
	localparam logic [MULT_W-1:0] MULT_RESET = 5'h00;
	localparam logic [DIV_W-1:0] DIV_RESET = 2'h0;
	localparam logic [FREQ_W-1:0] REF_MIN_KHZ = 32'h0000_2710;
	localparam logic [FREQ_W-1:0] REF_MAX_KHZ = 32'h0000_61a8;
	localparam logic [FREQ_W-1:0] OUT_MIN_KHZ = 32'h0000_2710;
	localparam logic [FREQ_W-1:0] OUT_MAX_KHZ = 32'h0000_ea60;
	localparam logic [FREQ_W-1:0] LOOP_MIN_KHZ = 32'h0002_6160;
	localparam logic [FREQ_W-1:0] LOOP_MAX_KHZ = 32'h0004_e200;
	localparam logic [31:0] RESET_VECTOR = 32'h0000_0000;

	typedef enum logic [4:0] {
		RST_CHIP = 5'h01,
		RST_WAKE = 5'h02,
		RST_FLASH = 5'h04,
		RST_RUN = 5'h08,
		RST_PDOWN = 5'h10
	} pcr_rst_e;

	typedef enum logic [2:0] {
		SW_IDLE = 3'h1,
		SW_GATE = 3'h2,
		SW_SWAP = 3'h4
	} pcr_sw_e;
endpackage

// ===== rtl/pcr_post_div.sv
// Post divider with 50 percent duty output
`timescale 1ns/1ns
module pcr_post_div
	import pcr_pkg::*;
#(
	parameter int DW = DIV_W
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic run,
	input wire logic [DW-1:0] div_sel,
	output logic div_out
);
	localparam int CW = 1 << DW;
	logic [CW-1:0] cnt_q;
	logic div_q;
	wire tap = cnt_q[div_sel];

	// Counter bit k toggles every 2^k cycles: ratio 2^(k+1), equal halves
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cnt_q <= '0;
			div_q <= 1'b0;
		end else begin
			cnt_q <= run ? cnt_q + 1'b1 : '0;
			div_q <= run & tap;
		end
	end
	assign div_out = div_q;
endmodule

// ===== rtl/pcr_wake_timer.sv
// Wake-up timer counting oscillator clocks after a start
`timescale 1ns/1ns
module pcr_wake_timer
	import pcr_pkg::*;
#(
	parameter int COUNT = WAKE_CLOCKS
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic start,
	input wire logic osc_running,
	output logic done
);
	localparam int CW = $clog2(COUNT + 1);
	localparam logic [CW-1:0] LAST = CW'(COUNT - 1);
	logic [CW-1:0] cnt_q;
	logic done_q;
	wire tick = osc_running & ~done_q;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cnt_q <= '0;
			done_q <= 1'b0;
		end else if (start) begin
			cnt_q <= '0;
			done_q <= 1'b0;
		end else if (tick) begin
			cnt_q <= cnt_q + 1'b1;
			done_q <= (cnt_q == LAST);
		end
	end
	assign done = done_q;
endmodule

// ===== rtl/pcr_clock_reset.sv
// PLL control, core clock selection and reset/wake-up sequencing
`timescale 1ns/1ns
module pcr_clock_reset
	import pcr_pkg::*;
#(
	parameter int LOCK_CNT = LOCK_CYCLES,
	parameter int WAKE_CNT = WAKE_CLOCKS
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic ext_reset_req,
	input wire logic watchdog_reset_req,
	input wire logic osc_running,
	input wire logic flash_init_done,
	input wire logic powerdown_req,
	input wire logic wake_event,
	input wire logic [KHZ_W-1:0] osc_khz,
	input wire logic cfg_write,
	input wire logic [MULT_W-1:0] cfg_mult,
	input wire logic [DIV_W-1:0] cfg_div,
	input wire logic cfg_enable,
	input wire logic cfg_connect,
	output logic internal_reset,
	output logic cpu_run,
	output logic osc_enable,
	output logic fetch_valid,
	output logic [31:0] fetch_addr,
	output logic pll_enabled,
	output logic pll_connected,
	output logic pll_lock,
	output logic pll_div_out,
	output logic core_clk_src_pll,
	output logic core_clk_gate_en,
	output logic [FREQ_W-1:0] loop_oscillator_khz,
	output logic [FREQ_W-1:0] cpu_core_clock_khz,
	output logic ref_in_range,
	output logic out_in_range,
	output logic loop_in_range
);
	localparam int LW = $clog2(LOCK_CNT + 1);
	localparam logic [LW-1:0] LOCK_LAST = LW'(LOCK_CNT - 1);
	localparam int GW = $clog2(SWITCH_GAP + 1);
	localparam logic [GW-1:0] GAP_LAST = GW'(SWITCH_GAP - 1);

	pcr_rst_e rst_q, rst_d;
	pcr_sw_e sw_q, sw_d;
	logic from_pdown_q, from_pdown_d;
	logic int_rst_q, run_q, fetch_q;
	logic [31:0] fetch_addr_q;
	logic [MULT_W-1:0] mult_q;
	logic [DIV_W-1:0] div_q;
	logic en_q, conn_q, lock_q;
	logic [LW-1:0] lock_cnt_q;
	logic src_q, gate_q;
	logic [GW-1:0] gap_q;
	logic [FREQ_W-1:0] out_khz_q, loop_khz_q;
	logic wake_done;

	// Reset sources and sequencing
	wire rst_src = ext_reset_req | watchdog_reset_req;
	wire in_chip = (rst_q == RST_CHIP);
	wire in_wake = (rst_q == RST_WAKE);
	wire in_flash = (rst_q == RST_FLASH);
	wire in_run = (rst_q == RST_RUN);
	wire in_pdown = (rst_q == RST_PDOWN);
	wire pdown_wake = in_pdown & wake_event & ~rst_src;
	wire timer_start = in_chip | pdown_wake;

	always_comb begin
		rst_d = rst_q;
		from_pdown_d = from_pdown_q;
		unique case (rst_q)
			RST_CHIP: begin
				from_pdown_d = 1'b0;
				if (!rst_src) begin
					rst_d = RST_WAKE;
				end
			end
			RST_WAKE: begin
				if (rst_src) begin
					rst_d = RST_CHIP;
				end else if (wake_done && osc_running) begin
					rst_d = from_pdown_q ? RST_RUN : RST_FLASH;
				end
			end
			RST_FLASH: begin
				if (rst_src) begin
					rst_d = RST_CHIP;
				end else if (flash_init_done) begin
					rst_d = RST_RUN;
				end
			end
			RST_RUN: begin
				from_pdown_d = 1'b0;
				if (rst_src) begin
					rst_d = RST_CHIP;
				end else if (powerdown_req) begin
					rst_d = RST_PDOWN;
				end
			end
			RST_PDOWN: begin
				if (rst_src) begin
					rst_d = RST_CHIP;
				end else if (wake_event) begin
					rst_d = RST_WAKE;
					from_pdown_d = 1'b1;
				end
			end
			default: begin
				rst_d = RST_CHIP;
			end
		endcase
	end

	wire int_rst_d = (rst_d == RST_CHIP) | ((rst_d != RST_RUN) & (rst_d != RST_PDOWN) & ~from_pdown_d);
	wire release_now = int_rst_q & ~int_rst_d;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rst_q <= RST_CHIP;
			from_pdown_q <= 1'b0;
			int_rst_q <= 1'b1;
			run_q <= 1'b0;
			fetch_q <= 1'b0;
			fetch_addr_q <= RESET_VECTOR;
		end else begin
			rst_q <= rst_d;
			from_pdown_q <= from_pdown_d;
			int_rst_q <= int_rst_d;
			run_q <= (rst_d == RST_RUN);
			fetch_q <= release_now;
			fetch_addr_q <= RESET_VECTOR;
		end
	end

	pcr_wake_timer #(
		.COUNT(WAKE_CNT)
	) u_wake (
		.clk(clk),
		.reset(reset),
		.start(timer_start),
		.osc_running(osc_running),
		.done(wake_done)
	);

	// PLL configuration, forced to defaults while internal reset is held
	wire cfg_take = cfg_write & ~int_rst_q;
	wire cfg_change = cfg_take & ((cfg_mult != mult_q) | (cfg_div != div_q));

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mult_q <= MULT_RESET;
			div_q <= DIV_RESET;
			en_q <= 1'b0;
			conn_q <= 1'b0;
		end else if (int_rst_q) begin
			mult_q <= MULT_RESET;
			div_q <= DIV_RESET;
			en_q <= 1'b0;
			conn_q <= 1'b0;
		end else if (cfg_take) begin
			mult_q <= cfg_mult;
			div_q <= cfg_div;
			en_q <= cfg_enable;
			conn_q <= cfg_connect;
		end
	end

	// Lock after settling time; restarts on disable or new ratio
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			lock_cnt_q <= '0;
			lock_q <= 1'b0;
		end else if (!en_q || cfg_change) begin
			lock_cnt_q <= '0;
			lock_q <= 1'b0;
		end else if (!lock_q) begin
			lock_cnt_q <= lock_cnt_q + 1'b1;
			lock_q <= (lock_cnt_q == LOCK_LAST);
		end
	end

	// Frequency plan: output = ref * M, loop = output * 2 * P
	wire [FREQ_W-1:0] mult_factor = FREQ_W'(mult_q) + 32'h0000_0001;
	wire [FREQ_W-1:0] out_khz_d = FREQ_W'(osc_khz) * mult_factor;
	wire [FREQ_W-1:0] loop_khz_d = out_khz_q << ({1'b0, div_q} + 3'h1);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			out_khz_q <= '0;
			loop_khz_q <= '0;
		end else begin
			out_khz_q <= out_khz_d;
			loop_khz_q <= loop_khz_d;
		end
	end

	assign ref_in_range = (FREQ_W'(osc_khz) >= REF_MIN_KHZ) & (FREQ_W'(osc_khz) <= REF_MAX_KHZ);
	assign out_in_range = (out_khz_q >= OUT_MIN_KHZ) & (out_khz_q <= OUT_MAX_KHZ);
	assign loop_in_range = (loop_khz_q >= LOOP_MIN_KHZ) & (loop_khz_q <= LOOP_MAX_KHZ);

	pcr_post_div #(
		.DW(DIV_W)
	) u_div (
		.clk(clk),
		.reset(reset),
		.run(en_q),
		.div_sel(div_q),
		.div_out(pll_div_out)
	);

	// Core clock source switch: gate, swap, ungate
	wire want_pll = en_q & lock_q & conn_q;
	wire gap_done = (gap_q == GAP_LAST);

	always_comb begin
		sw_d = sw_q;
		unique case (sw_q)
			SW_IDLE: begin
				if (want_pll != src_q) begin
					sw_d = SW_GATE;
				end
			end
			SW_GATE: begin
				if (gap_done) begin
					sw_d = SW_SWAP;
				end
			end
			SW_SWAP: begin
				if (gap_done) begin
					sw_d = SW_IDLE;
				end
			end
			default: begin
				sw_d = SW_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sw_q <= SW_IDLE;
			gap_q <= '0;
			src_q <= 1'b0;
			gate_q <= 1'b1;
		end else begin
			sw_q <= sw_d;
			gap_q <= (sw_d != sw_q) ? '0 : gap_q + 1'b1;
			gate_q <= (sw_d == SW_IDLE);
			if (sw_q == SW_GATE && gap_done) begin
				src_q <= want_pll;
			end
		end
	end

	assign internal_reset = int_rst_q;
	assign cpu_run = run_q;
	assign osc_enable = ~in_pdown;
	assign fetch_valid = fetch_q;
	assign fetch_addr = fetch_addr_q;
	assign pll_enabled = en_q;
	assign pll_connected = conn_q;
	assign pll_lock = lock_q;
	assign core_clk_src_pll = src_q;
	assign core_clk_gate_en = gate_q;
	assign loop_oscillator_khz = loop_khz_q;
	assign cpu_core_clock_khz = src_q ? out_khz_q : FREQ_W'(osc_khz);

	// Checking helpers
	localparam int AGE_W = 32;
	logic [AGE_W-1:0] en_age_q;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			en_age_q <= '0;
		end else begin
			en_age_q <= (!en_q || cfg_change) ? '0 : en_age_q + 1'b1;
		end
	end

	a_pll_off_reset: assert property (@(posedge clk) disable iff (reset)
		internal_reset |=> !pll_enabled && !pll_connected && !core_clk_src_pll || $past(core_clk_src_pll))
		else $error("PLL not off and bypassed during reset");
	a_lock_settle: assert property (@(posedge clk) disable iff (reset)
		$rose(pll_lock) |-> en_age_q == AGE_W'(LOCK_CNT))
		else $error("Lock reported before settling time");
	a_lock_drop: assert property (@(posedge clk) disable iff (reset)
		!pll_enabled |=> !pll_lock)
		else $error("Lock held while PLL disabled");
	a_core_source: assert property (@(posedge clk) disable iff (reset)
		core_clk_src_pll && core_clk_gate_en && sw_q == SW_IDLE |-> pll_enabled && pll_lock && pll_connected
			|| $changed(want_pll))
		else $error("Core clock from PLL while not running and connected");
	a_switch_gated: assert property (@(posedge clk) disable iff (reset)
		$changed(core_clk_src_pll) |-> !core_clk_gate_en ##1 !core_clk_gate_en)
		else $error("Clock source changed while ungated");
	a_reset_sources: assert property (@(posedge clk) disable iff (reset)
		ext_reset_req || watchdog_reset_req |=> internal_reset && !cpu_run)
		else $error("Reset source did not assert internal reset");
	a_release_cond: assert property (@(posedge clk) disable iff (reset)
		$fell(internal_reset) |-> $past(flash_init_done) && $past(!ext_reset_req) && in_run)
		else $error("Internal reset released too early");
	a_fetch_vector: assert property (@(posedge clk) disable iff (reset)
		$fell(internal_reset) |-> fetch_valid && fetch_addr == RESET_VECTOR)
		else $error("First fetch not at reset vector");
	a_wake_timer: assert property (@(posedge clk) disable iff (reset)
		$rose(cpu_run) |-> $past(wake_done) || $past(in_flash))
		else $error("Run resumed without wake-up timer");

	c_lock_seen: cover property (@(posedge clk) disable iff (reset) $rose(pll_lock));
	c_pll_switch: cover property (@(posedge clk) disable iff (reset) $rose(core_clk_src_pll));
	c_pdown_wake: cover property (@(posedge clk) disable iff (reset) in_pdown ##1 in_wake ##[1:1000] in_run);
endmodule

// ===== testbench/pcr_osc_flash_model.sv
// Oscillator start-up and flash initialisation model for the clock and reset block
`timescale 1ns/1ns
module pcr_osc_flash_model #(
	parameter int OSC_START = 3,
	parameter int FLASH_INIT = 6
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic chip_reset,
	input wire logic osc_enable,
	output logic osc_running,
	output logic flash_init_done
);
	int osc_cnt;
	int flash_cnt;
	// Oscillator stops at once when disabled and takes a few cycles to restart
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			osc_cnt <= 0;
		end else if (!osc_enable) begin
			osc_cnt <= 0;
		end else if (osc_cnt < OSC_START) begin
			osc_cnt <= osc_cnt + 1;
		end
	end
	assign osc_running = osc_enable && (osc_cnt >= OSC_START);
	// Flash starts over on every chip reset and needs a running oscillator
	always @(posedge clk or posedge reset) begin
		if (reset || chip_reset) begin
			flash_cnt <= 0;
		end else if (osc_running && flash_cnt < FLASH_INIT) begin
			flash_cnt <= flash_cnt + 1;
		end
	end
	assign flash_init_done = (flash_cnt >= FLASH_INIT);
endmodule

// ===== testbench/test_pcr_clock_reset.sv
// Self-checking testbench for the clock and reset control block
`timescale 1ns/1ns
module test_pcr_clock_reset;
	import pcr_pkg::*;
	localparam int LOCK_T = 20;
	localparam int WAKE_T = 8;
	localparam logic [19:0] OSC_A = 20'h02ee0;
	localparam logic [19:0] OSC_LOW = 20'h01f40;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic ext_reset_req = 1'b0;
	logic watchdog_reset_req = 1'b0;
	logic powerdown_req = 1'b0;
	logic wake_event = 1'b0;
	logic [KHZ_W-1:0] osc_khz = OSC_A;
	logic cfg_write = 1'b0;
	logic [MULT_W-1:0] cfg_mult = 5'h00;
	logic [DIV_W-1:0] cfg_div = 2'h0;
	logic cfg_enable = 1'b0;
	logic cfg_connect = 1'b0;
	wire osc_running, flash_init_done, internal_reset, cpu_run, osc_enable, fetch_valid;
	wire [31:0] fetch_addr;
	wire pll_enabled, pll_connected, pll_lock, pll_div_out, core_clk_src_pll, core_clk_gate_en;
	wire [FREQ_W-1:0] loop_oscillator_khz;
	wire [FREQ_W-1:0] cpu_core_clock_khz;
	wire ref_in_range, out_in_range, loop_in_range;
	int mismatches = 0;
	int checks_done = 0;
	int cycles = 0;
	int n;
	int k;
	int h;
	int early;
	logic gate_seen;
	logic [31:0] exp_loop;
	int m_tab [4] = '{0, 31, 2, 4};
	int d_tab [4] = '{0, 1, 2, 3};

	pcr_clock_reset #(.LOCK_CNT(LOCK_T), .WAKE_CNT(WAKE_T)) i_dut (.clk(clk), .reset(reset),
		.ext_reset_req(ext_reset_req), .watchdog_reset_req(watchdog_reset_req), .osc_running(osc_running),
		.flash_init_done(flash_init_done), .powerdown_req(powerdown_req), .wake_event(wake_event),
		.osc_khz(osc_khz), .cfg_write(cfg_write), .cfg_mult(cfg_mult), .cfg_div(cfg_div),
		.cfg_enable(cfg_enable), .cfg_connect(cfg_connect), .internal_reset(internal_reset), .cpu_run(cpu_run),
		.osc_enable(osc_enable), .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .pll_enabled(pll_enabled),
		.pll_connected(pll_connected), .pll_lock(pll_lock), .pll_div_out(pll_div_out),
		.core_clk_src_pll(core_clk_src_pll), .core_clk_gate_en(core_clk_gate_en),
		.loop_oscillator_khz(loop_oscillator_khz), .cpu_core_clock_khz(cpu_core_clock_khz),
		.ref_in_range(ref_in_range), .out_in_range(out_in_range), .loop_in_range(loop_in_range));

	pcr_osc_flash_model i_model (.clk(clk), .reset(reset), .chip_reset(ext_reset_req | watchdog_reset_req),
		.osc_enable(osc_enable), .osc_running(osc_running), .flash_init_done(flash_init_done));

	always #5 clk = ~clk;

	task end_sim;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			end_sim();
		end
	end

	task tick(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask

	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			$display("unexpected %s: expected %h seen %h", name, exp, got);
			mismatches++;
		end
	endtask

	task write_cfg(input logic [MULT_W-1:0] m, input logic [DIV_W-1:0] d, input logic en, input logic con);
		cfg_mult = m;
		cfg_div = d;
		cfg_enable = en;
		cfg_connect = con;
		cfg_write = 1'b1;
		tick(1);
		cfg_write = 1'b0;
	endtask

	task wait_run(output int c);
		for (c = 0; c < 500 && internal_reset !== 1'b0; c++) tick(1);
	endtask

	initial begin
		repeat (4) @(posedge clk);
		#1 reset = 1'b0;
		tick(1);
		chk("pll_enabled", 32'h0, pll_enabled);
		chk("core_src", 32'h0, core_clk_src_pll);
		chk("core_khz", 32'(OSC_A), cpu_core_clock_khz);
		write_cfg(5'h04, 2'h1, 1'b1, 1'b1);
		tick(1);
		chk("pll_enabled", 32'h0, pll_enabled);
		wait_run(n);
		chk("wake_len", 32'h1, 32'(n >= WAKE_T));
		chk("flash_done", 32'h1, flash_init_done);
		chk("fetch_valid", 32'h1, fetch_valid);
		chk("fetch_addr", RESET_VECTOR, fetch_addr);
		tick(1);
		chk("fetch_valid", 32'h0, fetch_valid);
		chk("cpu_run", 32'h1, cpu_run);
		chk("pll_lock", 32'h0, pll_lock);
		for (int i = 0; i < 4; i++) begin
			write_cfg(m_tab[i][MULT_W-1:0], d_tab[i][DIV_W-1:0], 1'b1, 1'b0);
			tick(2);
			exp_loop = 32'(OSC_A) * (m_tab[i] + 1) * (2 << d_tab[i]);
			chk("pll_enabled", 32'h1, pll_enabled);
			chk("loop_khz", exp_loop, loop_oscillator_khz);
			chk("loop_range", 32'(exp_loop >= LOOP_MIN_KHZ && exp_loop <= LOOP_MAX_KHZ), loop_in_range);
			exp_loop = 32'(OSC_A) * (m_tab[i] + 1);
			chk("out_range", 32'(exp_loop >= OUT_MIN_KHZ && exp_loop <= OUT_MAX_KHZ), out_in_range);
			for (k = 0; k < 40 && pll_div_out !== 1'b0; k++) tick(1);
			for (k = 0; k < 40 && pll_div_out !== 1'b1; k++) tick(1);
			for (h = 0; h < 40 && pll_div_out === 1'b1; h++) tick(1);
			chk("div_high", 32'(1 << d_tab[i]), 32'(h));
			for (k = 0; k < 40 && pll_div_out === 1'b0; k++) tick(1);
			chk("div_low", 32'(1 << d_tab[i]), 32'(k));
			chk("core_khz", 32'(OSC_A), cpu_core_clock_khz);
		end
		write_cfg(5'h04, 2'h1, 1'b1, 1'b0);
		early = 0;
		for (n = 0; n < 100 && pll_lock !== 1'b1; n++) begin
			if (core_clk_src_pll !== 1'b0) early++;
			tick(1);
		end
		chk("lock_time", 32'h1, 32'(n >= LOCK_T - 1 && n <= LOCK_T + 1));
		chk("src_before_lock", 32'h0, 32'(early));
		write_cfg(5'h04, 2'h1, 1'b1, 1'b1);
		gate_seen = 1'b1;
		for (n = 0; n < 20 && core_clk_src_pll !== 1'b1; n++) begin
			gate_seen = core_clk_gate_en;
			tick(1);
		end
		chk("gate_at_swap", 32'h0, gate_seen);
		tick(4);
		chk("gate_after", 32'h1, core_clk_gate_en);
		chk("pll_connected", 32'h1, pll_connected);
		chk("core_khz", 32'(OSC_A) * 5, cpu_core_clock_khz);
		write_cfg(5'h04, 2'h1, 1'b1, 1'b0);
		for (n = 0; n < 20 && core_clk_src_pll !== 1'b0; n++) tick(1);
		tick(4);
		chk("core_khz", 32'(OSC_A), cpu_core_clock_khz);
		osc_khz = OSC_LOW;
		tick(2);
		chk("ref_range", 32'h0, ref_in_range);
		osc_khz = OSC_A;
		tick(2);
		chk("ref_range", 32'h1, ref_in_range);
		powerdown_req = 1'b1;
		tick(1);
		powerdown_req = 1'b0;
		tick(4);
		chk("osc_enable", 32'h0, osc_enable);
		chk("cpu_run", 32'h0, cpu_run);
		wake_event = 1'b1;
		tick(1);
		wake_event = 1'b0;
		for (n = 0; n < 200 && cpu_run !== 1'b1; n++) tick(1);
		chk("wake_len", 32'h1, 32'(n >= WAKE_T && n < 200));
		chk("int_reset", 32'h0, internal_reset);
		for (int s = 0; s < 2; s++) begin
			ext_reset_req = (s == 0);
			watchdog_reset_req = (s == 1);
			tick(30);
			chk("int_reset", 32'h1, internal_reset);
			chk("pll_enabled", 32'h0, pll_enabled);
			chk("core_src", 32'h0, core_clk_src_pll);
			ext_reset_req = 1'b0;
			watchdog_reset_req = 1'b0;
			wait_run(n);
			chk("wake_len", 32'h1, 32'(n >= WAKE_T && n < 500));
		end
		end_sim();
	end
endmodule
